// [logic/led_fault_latch_and_current_control.sv]
// Top of the LED sink control: fault latch, soft-start switching and
// current code storage for 48 channels in three color groups.
// Assumes grayscale clock and comparator outputs arrive asynchronously;
// PWM on requests, control fields and write strobes come from core_clk_i.
//
// Behaviour
// RQ1: On channel above short threshold flags short.
// RQ2: Short threshold level follows threshold select field.
// RQ3: Flags captured on 33rd grayscale clock.
// RQ4: Off channels store zero short flag.
// RQ5: On channel below open threshold flags open.
// RQ6: Forty-eight sinks split into eight switching groups.
// RQ7: Group order 4/11,0/15,5/10,1/14,2/13,6/9,3/12,7/8.
// RQ8: Groups switch on and off in sequence.
// RQ9: Gap between groups is one parameter step; the sequencer loads successive groups STEP_CYCLES + 2 core cycles apart.
// RQ10: Maximum current codes reset to zero.
// RQ11: Current code changes only after identical double write.
// RQ12: Each color has a three-bit current code.
// RQ13: Host uses codes six, seven above 3.6 V.
// RQ14: Host changes current codes with outputs off.
// RQ15: Full scale only when correction, brightness 7Fh.
// RQ16: Each channel holds seven-bit correction code.
// RQ17: Host loads correction codes before enabling outputs.
`timescale 1ns/1ps
`include "led_ctl_params.svh"

module led_fault_latch_and_current_control (
  input  wire logic                      core_clk_i,
  input  wire logic                      reset_i,
  input  wire logic                      grayscale_clock_i,
  input  wire logic                      display_start_i,
  input  wire led_ctl_pkg::chan_vec_type channel_on_req_i,
  input  wire led_ctl_pkg::chan_vec_type above_short_i,
  input  wire led_ctl_pkg::chan_vec_type below_open_i,
  input  wire logic [`THR_BITS-1:0]      short_threshold_select_i,
  input  wire logic                      max_current_write_i,
  input  wire led_ctl_pkg::mc_set_type   max_current_code_i,
  input  wire logic                      dot_correction_write_i,
  input  wire led_ctl_pkg::dc_set_type   dot_correction_code_i,
  input  wire led_ctl_pkg::bc_set_type   group_brightness_code_i,
  output led_ctl_pkg::chan_vec_type      channel_output_o,
  output led_ctl_pkg::chan_vec_type      short_fault_flag_o,
  output led_ctl_pkg::chan_vec_type      open_fault_flag_o,
  output logic [`THR_BITS-1:0]           short_threshold_level_o,
  output led_ctl_pkg::mc_set_type        group_max_current_code_o,
  output led_ctl_pkg::dc_set_type        channel_dot_correction_code_o,
  output led_ctl_pkg::chan_vec_type      full_scale_o,
  output logic                           dot_correction_loaded_o
);
  import led_ctl_pkg::*;

  // Grayscale clock synchroniser and edge detection.
  logic        gs_s1;
  logic        gs_s2;
  logic        gs_s3;
  logic        gs_level;
  logic        next_gs_level;
  logic        gs_rise;
  logic [5:0]  gs_count;
  logic [5:0]  next_gs_count;
  logic        capture;
  logic        next_capture;

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      gs_s1 <= 1'b0;
      gs_s2 <= 1'b0;
      gs_s3 <= 1'b0;
    end else begin
      gs_s1 <= grayscale_clock_i;
      gs_s2 <= gs_s1;
      gs_s3 <= gs_s2;
    end
  end

  // A level change counts once the second and third stages agree.
  always_comb begin
    next_gs_level = gs_level;
    if (gs_s2 == gs_s3) begin
      next_gs_level = gs_s3;
    end
    gs_rise = next_gs_level & ~gs_level;
  end

  // Counts grayscale edges since display start; saturates past capture.
  // A start that meets a rise counts that rise as the first one, so no
  // edge is lost between display cycles.
  always_comb begin
    next_gs_count = gs_count;
    next_capture  = 1'b0;
    if (display_start_i) begin
      next_gs_count = gs_rise ? `GS_COUNT_ONE : `GS_COUNT_ZERO;
    end else if (gs_rise && gs_count != `GS_COUNT_MAX) begin
      next_gs_count = gs_count + 6'h01;
    end
    if (gs_rise && next_gs_count == `CAPTURE_COUNT) begin
      next_capture = 1'b1; // RQ3
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      gs_level <= 1'b0;
      gs_count <= `GS_COUNT_ZERO;
      capture  <= 1'b0;
    end else begin
      gs_level <= next_gs_level;
      gs_count <= next_gs_count;
      capture  <= next_capture;
    end
  end

  // Comparator outputs cross in through three stages per bit.
  // Only the second stage reads the first, guarding against metastability.
  chan_vec_type sh_s1;
  chan_vec_type sh_s2;
  chan_vec_type sh_s3;
  chan_vec_type sh_stable;
  chan_vec_type next_sh_stable;
  chan_vec_type op_s1;
  chan_vec_type op_s2;
  chan_vec_type op_s3;
  chan_vec_type op_stable;
  chan_vec_type next_op_stable;

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sh_s1 <= '0;
      sh_s2 <= '0;
      sh_s3 <= '0;
      op_s1 <= '0;
      op_s2 <= '0;
      op_s3 <= '0;
    end else begin
      sh_s1 <= above_short_i;
      sh_s2 <= sh_s1;
      sh_s3 <= sh_s2;
      op_s1 <= below_open_i;
      op_s2 <= op_s1;
      op_s3 <= op_s2;
    end
  end

  // Takes the third stage where it agrees with the second, else holds.
  function automatic chan_vec_type settled(input chan_vec_type s2,
                                           input chan_vec_type s3,
                                           input chan_vec_type held);
    return (s3 & ~(s2 ^ s3)) | (held & (s2 ^ s3));
  endfunction

  always_comb begin
    next_sh_stable = settled(sh_s2, sh_s3, sh_stable);
    next_op_stable = settled(op_s2, op_s3, op_stable);
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sh_stable <= '0;
      op_stable <= '0;
    end else begin
      sh_stable <= next_sh_stable;
      op_stable <= next_op_stable;
    end
  end

  // Validity follows the programmed request, not the staggered output,
  // so a channel still waiting for its group is judged as on.
  fault_latch u_fault_latch (
    .core_clk_i         (core_clk_i),
    .reset_i            (reset_i),
    .capture_i          (capture),
    .channel_on_i       (channel_on_req_i),
    .above_short_i      (sh_stable),
    .below_open_i       (op_stable),
    .short_fault_flag_o (short_fault_flag_o),
    .open_fault_flag_o  (open_fault_flag_o)
  );

  // Threshold select drives the analog short comparator reference.
  // The analog mapping of each level lies outside this block.
  logic [`THR_BITS-1:0] next_thr;

  always_comb begin
    next_thr = short_threshold_select_i; // RQ2
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      short_threshold_level_o <= `THR_RESET;
    end else begin
      short_threshold_level_o <= next_thr;
    end
  end

  // Soft-start: outputs follow requests one group at a time.
  // A request change mid-walk reaches only groups not yet loaded; the
  // sequencer then starts a fresh walk to finish the rest.
  stagger_if strobe ();
  chan_vec_type next_out;
  logic         change_pending;

  assign change_pending = (channel_on_req_i != channel_output_o);

  stagger_sequencer u_seq (
    .core_clk_i       (core_clk_i),
    .reset_i          (reset_i),
    .change_pending_i (change_pending),
    .strobe           (strobe.seq)
  );

  genvar gi;
  generate
    for (gi = 0; gi < `LED_CHANNELS; gi++) begin : g_out
      always_comb begin
        next_out[gi] = channel_output_o[gi];
        if (strobe.load &&
            strobe.group == group_of(gi % `LED_PER_COLOR)) begin // RQ6 RQ7
          next_out[gi] = channel_on_req_i[gi]; // RQ8
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      channel_output_o <= '0;
    end else begin
      channel_output_o <= next_out;
    end
  end

  // Maximum current codes take a new value only on a repeated write.
  // The last value stays armed across idle cycles; a differing write
  // replaces it, so a lone write never changes the active code.
  mc_set_type mc_last;
  mc_set_type next_mc_last;
  logic       mc_armed;
  logic       next_mc_armed;
  mc_set_type next_mc;

  always_comb begin
    next_mc_last  = mc_last;
    next_mc_armed = mc_armed;
    next_mc       = group_max_current_code_o; // RQ12
    if (max_current_write_i) begin
      next_mc_last  = max_current_code_i;
      next_mc_armed = 1'b1;
      if (mc_armed && mc_last == max_current_code_i) begin
        next_mc = max_current_code_i; // RQ11
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      mc_last                  <= '0;
      mc_armed                 <= 1'b0;
      group_max_current_code_o <= {`LED_COLORS{`MC_RESET}}; // RQ10
    end else begin
      mc_last                  <= next_mc_last;
      mc_armed                 <= next_mc_armed;
      group_max_current_code_o <= next_mc;
    end
  end

  // Dot correction storage and full-scale indication per channel.
  // Codes clear at reset; the loaded flag warns the host that outputs
  // must wait for a first write. Full scale lags the codes by a cycle.
  dc_set_type   next_dc;
  logic         next_dc_loaded;
  chan_vec_type next_full;

  always_comb begin
    next_dc        = channel_dot_correction_code_o;
    next_dc_loaded = dot_correction_loaded_o;
    if (dot_correction_write_i) begin
      next_dc        = dot_correction_code_i; // RQ16
      next_dc_loaded = 1'b1; // RQ17
    end
  end

  generate
    for (gi = 0; gi < `LED_CHANNELS; gi++) begin : g_full
      always_comb begin
        next_full[gi] = (channel_dot_correction_code_o[gi] == `FULL_CODE) &&
          (group_brightness_code_i[gi / `LED_PER_COLOR] == `FULL_CODE); // RQ15
      end
    end
  endgenerate

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      channel_dot_correction_code_o <= {`LED_CHANNELS{`DC_RESET}};
      dot_correction_loaded_o       <= 1'b0;
      full_scale_o                  <= '0;
    end else begin
      channel_dot_correction_code_o <= next_dc;
      dot_correction_loaded_o       <= next_dc_loaded;
      full_scale_o                  <= next_full;
    end
  end

endmodule

// [logic/led_ctl_params.svh]
// Numeric constants for the LED fault latch and current control block.
// Assumes it is included by bare name from every design file that needs it.
`ifndef LED_CTL_PARAMS_SVH
`define LED_CTL_PARAMS_SVH

`define LED_CHANNELS     48
`define LED_PER_COLOR    16
`define LED_COLORS       3
`define LED_GROUPS       8
`define GROUP_W          3
`define LAST_GROUP       3'h7
`define FIRST_GROUP      3'h0
`define CAPTURE_COUNT    6'h21
`define GS_COUNT_MAX     6'h3F
`define GS_COUNT_ZERO    6'h00
`define GS_COUNT_ONE     6'h01
`define MC_BITS          3
`define MC_RESET         3'h0
`define DC_BITS          7
`define DC_RESET         7'h00
`define FULL_CODE        7'h7F
`define THR_BITS         2
`define THR_RESET        2'h0
`define CLK_PERIOD_NS    10
`define STEP_DELAY_NS    20
`define STEP_CYCLES      ((`STEP_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DELAY_W          8
`define DELAY_ZERO       8'h00

`endif

// [logic/led_ctl_pkg.sv]
// Types and the group decode shared by the LED control modules.
// Assumes led_ctl_params.svh is on the include path.
`include "led_ctl_params.svh"

package led_ctl_pkg;

  typedef logic [`LED_CHANNELS-1:0]                 chan_vec_type;
  typedef logic [`GROUP_W-1:0]                      group_type;
  typedef logic [`LED_COLORS-1:0][`MC_BITS-1:0]     mc_set_type;
  typedef logic [`LED_COLORS-1:0][`DC_BITS-1:0]     bc_set_type;
  typedef logic [`LED_CHANNELS-1:0][`DC_BITS-1:0]   dc_set_type;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_LOAD,
    SEQ_WAIT
  } seq_state_type;

  // Maps a channel index within its color to its soft-start group.
  function automatic group_type group_of(input int unsigned idx);
    group_type g;
    g = `FIRST_GROUP;
    case (idx)
      4, 11: g = 3'h0;
      0, 15: g = 3'h1;
      5, 10: g = 3'h2;
      1, 14: g = 3'h3;
      2, 13: g = 3'h4;
      6, 9:  g = 3'h5;
      3, 12: g = 3'h6;
      7, 8:  g = 3'h7;
      default: g = `FIRST_GROUP;
    endcase
    return g;
  endfunction

endpackage

// [logic/stagger_if.sv]
// Carries the soft-start group strobe from the sequencer to the output stage.
// Assumes a single clock domain shared by both ends.
`timescale 1ns/1ps

interface stagger_if;
  import led_ctl_pkg::*;
  logic      load;
  group_type group;
  modport seq (output load, output group);
  modport app (input load, input group);
endinterface

// [logic/fault_latch.sv]
// Shared short/open fault flag latch for all output channels.
// Assumes comparator inputs are already synchronised to core_clk_i.
`timescale 1ns/1ps
`include "led_ctl_params.svh"

module fault_latch (
  input  wire logic                      core_clk_i,
  input  wire logic                      reset_i,
  input  wire logic                      capture_i,
  input  wire led_ctl_pkg::chan_vec_type channel_on_i,
  input  wire led_ctl_pkg::chan_vec_type above_short_i,
  input  wire led_ctl_pkg::chan_vec_type below_open_i,
  output led_ctl_pkg::chan_vec_type      short_fault_flag_o,
  output led_ctl_pkg::chan_vec_type      open_fault_flag_o
);
  import led_ctl_pkg::*;

  chan_vec_type next_short;
  chan_vec_type next_open;

  // Off channels always store a clear flag.
  always_comb begin
    next_short = short_fault_flag_o;
    next_open  = open_fault_flag_o;
    if (capture_i) begin // RQ3
      next_short = above_short_i & channel_on_i; // RQ1 RQ4
      next_open  = below_open_i & channel_on_i; // RQ5
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      short_fault_flag_o <= '0;
      open_fault_flag_o  <= '0;
    end else begin
      short_fault_flag_o <= next_short;
      open_fault_flag_o  <= next_open;
    end
  end

endmodule

// [logic/stagger_sequencer.sv]
// Walks the eight soft-start groups in order with a fixed gap between them.
// Assumes change_pending_i comes from logic on core_clk_i.
`timescale 1ns/1ps
`include "led_ctl_params.svh"

module stagger_sequencer #(
  parameter logic [`DELAY_W-1:0] STEP_CYCLES = `DELAY_W'(`STEP_CYCLES)
) (
  input  wire logic   core_clk_i,
  input  wire logic   reset_i,
  input  wire logic   change_pending_i,
  stagger_if.seq      strobe
);
  import led_ctl_pkg::*;

  seq_state_type        state;
  seq_state_type        next_state;
  group_type            group;
  group_type            next_group;
  logic [`DELAY_W-1:0]  delay;
  logic [`DELAY_W-1:0]  next_delay;
  logic                 load;
  logic                 next_load;

  always_comb begin
    next_state = state;
    next_group = group;
    next_delay = delay;
    next_load  = 1'b0;
    case (state)
      SEQ_IDLE: begin
        if (change_pending_i) begin // RQ8
          next_state = SEQ_LOAD;
          next_group = `FIRST_GROUP;
        end
      end
      SEQ_LOAD: begin
        next_load  = 1'b1;
        next_delay = STEP_CYCLES; // RQ9
        next_state = SEQ_WAIT;
      end
      SEQ_WAIT: begin
        if (delay > `DELAY_ZERO) begin
          next_delay = delay - `DELAY_W'(1);
        end else if (group == `LAST_GROUP) begin
          next_state = SEQ_IDLE;
        end else begin
          next_group = group + `GROUP_W'(1); // RQ7
          next_state = SEQ_LOAD;
        end
      end
      default: next_state = SEQ_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state <= SEQ_IDLE;
      group <= `FIRST_GROUP;
      delay <= `DELAY_ZERO;
      load  <= 1'b0;
    end else begin
      state <= next_state;
      group <= next_group;
      delay <= next_delay;
      load  <= next_load;
    end
  end

  assign strobe.load  = load;
  assign strobe.group = group;

endmodule

// [test/gs_host.sv]
// Host model that plays the grayscale clock and display start pins.
// Assumes its tasks are called from a process timed on core_clk_i.
`timescale 1ns/1ps

module gs_host (
  input  wire logic core_clk_i,
  output logic      grayscale_clock_o,
  output logic      display_start_o
);
  initial begin
    grayscale_clock_o = 1'b0;
    display_start_o   = 1'b0;
  end

  // Each phase lasts four core cycles so the synchroniser sees every edge.
  task automatic rise();
    repeat (4) @(posedge core_clk_i);
    #1 grayscale_clock_o = 1'b1;
    repeat (4) @(posedge core_clk_i);
    #1 grayscale_clock_o = 1'b0;
  endtask

  // Restarts the count, then plays n rises; the clock idles low afterwards.
  task automatic frame(input int n);
    @(posedge core_clk_i);
    #1 display_start_o = 1'b1;
    @(posedge core_clk_i);
    #1 display_start_o = 1'b0;
    repeat (n) rise();
  endtask
endmodule

// [test/led_ctl_checker.sv]
// Concurrent checks on the ports of the LED sink control top module.
// Assumes it is bound to led_fault_latch_and_current_control.
`timescale 1ns/1ps
`include "led_ctl_params.svh"

module led_ctl_checker (
  input wire logic                      core_clk_i,
  input wire logic                      reset_i,
  input wire logic                      grayscale_clock_i,
  input wire led_ctl_pkg::chan_vec_type channel_on_req_i,
  input wire logic [`THR_BITS-1:0]      short_threshold_select_i,
  input wire logic                      max_current_write_i,
  input wire led_ctl_pkg::mc_set_type   max_current_code_i,
  input wire logic                      dot_correction_write_i,
  input wire led_ctl_pkg::dc_set_type   dot_correction_code_i,
  input wire led_ctl_pkg::bc_set_type   group_brightness_code_i,
  input wire led_ctl_pkg::chan_vec_type channel_output_o,
  input wire led_ctl_pkg::chan_vec_type short_fault_flag_o,
  input wire led_ctl_pkg::chan_vec_type open_fault_flag_o,
  input wire logic [`THR_BITS-1:0]      short_threshold_level_o,
  input wire led_ctl_pkg::mc_set_type   group_max_current_code_o,
  input wire led_ctl_pkg::dc_set_type   channel_dot_correction_code_o,
  input wire led_ctl_pkg::chan_vec_type full_scale_o,
  input wire logic                      dot_correction_loaded_o
);
  import led_ctl_pkg::*;
  localparam int GRP [16] = '{1, 3, 4, 6, 0, 2, 5, 7, 7, 5, 2, 0, 6, 4, 3, 1};
  chan_vec_type prev_out, chg, full_now;
  logic [7:0]   fit;

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      prev_out <= '0;
    end else begin
      prev_out <= channel_output_o;
    end
  end

  // Marks which single group could account for every output that changed.
  always_comb begin
    chg = channel_output_o ^ prev_out;
    fit = '1;
    for (int i = 0; i < 48; i++) begin
      full_now[i] = channel_dot_correction_code_o[i] == `FULL_CODE &&
                    group_brightness_code_i[i / 16] == `FULL_CODE;
      for (int g = 0; g < 8; g++) begin
        if (chg[i] && GRP[i % 16] != g) begin
          fit[g] = 1'b0;
        end
      end
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  sequence quiet2;
    chg == '0 ##1 chg == '0;
  endsequence

  a_group_batch: assert property (chg != '0 |-> fit != '0)
    else $error("outputs switched across groups");
  a_group_gap: assert property (chg != '0 |=> quiet2)
    else $error("groups switched without a gap");
  a_short_on: assert property (!$stable(short_fault_flag_o) |->
    (short_fault_flag_o & ~$past(channel_on_req_i)) == '0)
    else $error("short flag on an off channel");
  a_open_on: assert property (!$stable(open_fault_flag_o) |->
    (open_fault_flag_o & ~$past(channel_on_req_i)) == '0)
    else $error("open flag on an off channel");
  a_flag_quiet: assert property ($stable(grayscale_clock_i) [*8] |=>
    $stable(short_fault_flag_o) && $stable(open_fault_flag_o))
    else $error("flags moved without grayscale edge");
  a_thr_copy: assert property (!$past(reset_i) |->
    short_threshold_level_o == $past(short_threshold_select_i))
    else $error("threshold level not following select");
  a_mc_cause: assert property (!$stable(group_max_current_code_o) |->
    $past(max_current_write_i) &&
    group_max_current_code_o == $past(max_current_code_i))
    else $error("current code changed without a write");
  a_mc_reset: assert property ($past(reset_i) |->
    group_max_current_code_o == '0)
    else $error("current code not zero after reset");
  a_dc_load: assert property (dot_correction_write_i |=>
    channel_dot_correction_code_o == $past(dot_correction_code_i) &&
    dot_correction_loaded_o)
    else $error("correction codes not loaded");
  a_full_scale: assert property (!$past(reset_i) |->
    full_scale_o == $past(full_now))
    else $error("full scale flag wrong");
endmodule

bind led_fault_latch_and_current_control led_ctl_checker u_chk (
  .core_clk_i, .reset_i, .grayscale_clock_i, .channel_on_req_i,
  .short_threshold_select_i, .max_current_write_i, .max_current_code_i,
  .dot_correction_write_i, .dot_correction_code_i, .group_brightness_code_i,
  .channel_output_o, .short_fault_flag_o, .open_fault_flag_o,
  .short_threshold_level_o, .group_max_current_code_o,
  .channel_dot_correction_code_o, .full_scale_o, .dot_correction_loaded_o
);

// [test/testbench.sv]
// Self-checking bench for the LED sink control top module.
// Assumes the design files, gs_host and the checker are compiled first.
`timescale 1ns/1ps
`include "led_ctl_params.svh"
`define CHK(a, e, m) begin checked++; if ((a) !== (e)) begin num_errors++; \
  $display("BAD %0t %s", $time, m); end end

module testbench;
  import led_ctl_pkg::*;
  localparam int GRP [16] = '{1, 3, 4, 6, 0, 2, 5, 7, 7, 5, 2, 0, 6, 4, 3, 1};
  localparam chan_vec_type P = 48'hF0F0_AAAA_5555;
  logic                 core_clk_i, reset_i, display_start_i;
  logic                 grayscale_clock_i, dot_correction_loaded_o;
  logic                 max_current_write_i, dot_correction_write_i;
  logic [`THR_BITS-1:0] short_threshold_select_i, short_threshold_level_o;
  chan_vec_type         channel_on_req_i, above_short_i, below_open_i;
  chan_vec_type         channel_output_o, short_fault_flag_o;
  chan_vec_type         open_fault_flag_o, full_scale_o, es, eo, fs;
  mc_set_type           max_current_code_i, group_max_current_code_o, v;
  dc_set_type           dot_correction_code_i, channel_dot_correction_code_o;
  bc_set_type           group_brightness_code_i;
  int                   num_errors, checked;

  led_fault_latch_and_current_control dut (.*);
  gs_host gs (
    .core_clk_i        (core_clk_i),
    .grayscale_clock_o (grayscale_clock_i),
    .display_start_o   (display_start_i)
  );

  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask

  task automatic mc_write(input mc_set_type c);
    tick(1);
    max_current_write_i = 1'b1;
    max_current_code_i  = c;
    tick(1);
    max_current_write_i = 1'b0;
  endtask

  // Records the cycle at which each output reaches its new request.
  task automatic walk(input chan_vec_type r);
    int t [48];
    t = '{default: -1};
    channel_on_req_i = r;
    for (int n = 0; n < 34; n++) begin
      tick(1);
      for (int i = 0; i < 48; i++)
        if (t[i] < 0 && channel_output_o[i] === r[i]) t[i] = n;
    end
    for (int i = 0; i < 48; i++)
      `CHK(t[i], 2 + (`STEP_CYCLES + 2) * GRP[i % 16], "walk")
  endtask

  task automatic stop_test();
    if (num_errors == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    #100000;
    num_errors++;
    stop_test();
  end

  initial begin
    num_errors = 0;
    checked = 0;
    reset_i = 1'b1;
    {max_current_write_i, dot_correction_write_i} = '0;
    {short_threshold_select_i, max_current_code_i} = '0;
    {channel_on_req_i, above_short_i, below_open_i} = '0;
    dot_correction_code_i = '0;
    group_brightness_code_i = {7'h7F, 7'h7E, 7'h7F};
    repeat (6) @(posedge core_clk_i);
    #1 reset_i = 1'b0;
    tick(1);
    `CHK(group_max_current_code_o, 9'h000, "mc reset")
    `CHK(dot_correction_loaded_o, 1'b0, "loaded at reset")
    for (int s = 0; s < 4; s++) begin
      short_threshold_select_i = 2'(s);
      tick(2);
      `CHK(short_threshold_level_o, 2'(s), "threshold")
    end
    mc_write({3'h6, 3'h7, 3'h5});
    tick(1);
    `CHK(group_max_current_code_o, 9'h000, "single write")
    for (int k = 0; k < 8; k++) begin
      v = {3'(k), 3'(7 - k), 3'(k ^ 5)};
      mc_write(v);
      mc_write(v);
      tick(1);
      `CHK(group_max_current_code_o, v, "double write")
    end
    mc_write({3'h1, 3'h2, 3'h3});
    mc_write({3'h3, 3'h2, 3'h1});
    tick(1);
    `CHK(group_max_current_code_o, v, "differing pair")
    for (int i = 0; i < 48; i++) begin
      dot_correction_code_i[i] = (i == 1) ? 7'h7E : `FULL_CODE;
      fs[i] = (i != 1) && (i / 16 != 1);
    end
    tick(1);
    dot_correction_write_i = 1'b1;
    tick(1);
    dot_correction_write_i = 1'b0;
    tick(2);
    `CHK(channel_dot_correction_code_o, dot_correction_code_i, "dc")
    `CHK(dot_correction_loaded_o, 1'b1, "dc loaded")
    `CHK(full_scale_o, fs, "full scale")
    walk('1);
    walk('0);
    channel_on_req_i = P;
    tick(40);
    es = '0;
    eo = '0;
    for (int k = 0; k < 2; k++) begin
      above_short_i = k ? 48'h0FF0_CCCC_3333 : 48'hF00F_3333_CCCC;
      below_open_i = k ? 48'h00FF_0F0F_FFFF : 48'hFF00_F0F0_0000;
      gs.frame(32);
      tick(12);
      `CHK(short_fault_flag_o, es, "early short capture")
      `CHK(open_fault_flag_o, eo, "early open capture")
      gs.rise();
      tick(12);
      es = above_short_i & P;
      eo = below_open_i & P;
      `CHK(short_fault_flag_o, es, "short flags")
      `CHK(open_fault_flag_o, eo, "open flags")
    end
    stop_test();
  end
endmodule
